// file: rsx_exec.sv
// Purpose: decode and execute of rotate-through-carry and halt instructions
// Assumes: one instruction per clock, file register read is combinational
// Notes: results are registered and appear one clock after the instruction
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsx_exec
    import rsx_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // instruction stream
    input wire logic i_instr_valid,
    input wire logic [13:0] i_instr,
    // file register and flags
    output logic [6:0] o_file_raddr,
    input wire logic [7:0] i_file_rdata,
    input wire logic i_carry,
    output logic o_file_we,
    output logic [6:0] o_file_waddr,
    output logic o_w_we,
    output logic [7:0] o_result,
    output logic o_carry_we,
    output logic o_carry,
    output logic o_zero_we,
    output logic o_dc_we,
    // watchdog and power
    input wire logic i_watchdog_expired,
    input wire logic i_wake_pin,
    output logic o_watchdog_timer_clear,
    output logic o_prescaler_clear,
    output logic o_watchdog_expiry_bit,
    output logic o_power_down_bit,
    output logic o_osc_stop,
    // interrupt
    output logic o_irq
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic ctrl_en;
    rsx_state_t state;
    rsx_state_t next_state;
    logic accept;
    logic is_rotr;
    logic is_rotl;
    logic is_rot;
    logic is_halt;
    logic dest_file;
    logic [7:0] next_result;
    logic next_carry;
    logic wake_s1;
    logic wake_s2;
    logic wake_s3;
    logic wake;

    // halted core ignores the stream, as its clock would be gone
    assign accept = i_instr_valid && ctrl_en && (state == RSX_RUN);
    assign is_rotr = accept && (i_instr[13:8] == OPC_ROTR_HI);
    assign is_rotl = accept && (i_instr[13:8] == OPC_ROTL_HI);
    assign is_rot = is_rotr || is_rotl;
    assign is_halt = accept && (i_instr == OPC_HALT);
    assign dest_file = i_instr[DEST_BIT];
    assign o_file_raddr = i_instr[FADDR_W-1:0];

    always_comb begin
        next_result = {i_carry, i_file_rdata[7:1]};
        next_carry = i_file_rdata[0];
        if (is_rotl) begin
            next_result = {i_file_rdata[6:0], i_carry};
            next_carry = i_file_rdata[7];
        end
    end

    // ------------------------------------------------------------
    // rotate execute
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_file_we <= 1'b0;
            o_w_we <= 1'b0;
            o_carry_we <= 1'b0;
            o_file_waddr <= 7'h00;
            o_result <= 8'h00;
            o_carry <= 1'b0;
        end else begin
            // single-cycle pulses, one per accepted rotate
            o_file_we <= is_rot && dest_file;
            o_w_we <= is_rot && !dest_file;
            o_carry_we <= is_rot;
            if (is_rot) begin
                o_file_waddr <= i_instr[FADDR_W-1:0];
                o_result <= next_result;
                o_carry <= next_carry;
            end
        end
    end

    // zero and digit-carry never written by this block
    assign o_zero_we = 1'b0;
    assign o_dc_we = 1'b0;

    // ------------------------------------------------------------
    // wake synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
        end else begin
            wake_s1 <= i_wake_pin;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end
    // agreement of the later stages filters a one-cycle glitch
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wake <= 1'b0;
        end else if (wake_s2 == wake_s3) begin
            wake <= wake_s2;
        end
    end

    // ------------------------------------------------------------
    // halt state machine
    // ------------------------------------------------------------
    always_comb begin
        case (state)
            RSX_RUN: begin
                next_state = is_halt ? RSX_HALTED : RSX_RUN;
            end
            RSX_HALTED: begin
                next_state = wake ? RSX_RUN : RSX_HALTED;
            end
            default: begin
                next_state = RSX_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= RSX_RUN;
        end else begin
            state <= next_state;
        end
    end

    assign o_osc_stop = (state == RSX_HALTED);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_watchdog_timer_clear <= 1'b0;
            o_prescaler_clear <= 1'b0;
        end else begin
            o_watchdog_timer_clear <= is_halt;
            o_prescaler_clear <= is_halt;
        end
    end

    // halt wins over a watchdog expiry in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_watchdog_expiry_bit <= EXPIRY_RST;
            o_power_down_bit <= PWRDN_RST;
        end else if (is_halt) begin
            o_watchdog_expiry_bit <= 1'b1;
            o_power_down_bit <= 1'b0;
        end else if (i_watchdog_expired) begin
            o_watchdog_expiry_bit <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clr;

    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && i_penable && !i_pwrite;
    assign mapped = (i_paddr == REG_CTRL) || (i_paddr == REG_STATUS) ||
                    (i_paddr == REG_IRQ_STAT) || (i_paddr == REG_IRQ_MASK);
    // zero wait states keep the core stream free of bus stalls
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctrl_en <= CTRL_EN_RST;
            irq_mask <= IRQ_MASK_RST;
        end else if (wr_acc) begin
            if (i_paddr == REG_CTRL) begin
                ctrl_en <= i_pwdata[CTRL_EN_BIT];
            end
            if (i_paddr == REG_IRQ_MASK) begin
                irq_mask <= i_pwdata[IRQ_W-1:0];
            end
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[IRQ_ROT_BIT] = is_rot;
        irq_event[IRQ_HALT_BIT] = is_halt;
        irq_event[IRQ_WAKE_BIT] = (state == RSX_HALTED) && wake;
        irq_clr = '0;
        if (wr_acc && (i_paddr == REG_IRQ_STAT)) begin
            irq_clr = i_pwdata[IRQ_W-1:0];
        end
    end

    // a new event beats a write-one clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_event;
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= 32'h0000_0000;
            case (i_paddr)
                REG_CTRL: begin
                    o_prdata[CTRL_EN_BIT] <= ctrl_en;
                end
                REG_STATUS: begin
                    o_prdata[ST_HALTED_BIT] <= (state == RSX_HALTED);
                    o_prdata[ST_EXPIRY_BIT] <= o_watchdog_expiry_bit;
                    o_prdata[ST_PWRDN_BIT] <= o_power_down_bit;
                    o_prdata[ST_CARRY_BIT] <= o_carry;
                end
                REG_IRQ_STAT: begin
                    o_prdata[IRQ_W-1:0] <= irq_stat;
                end
                REG_IRQ_MASK: begin
                    o_prdata[IRQ_W-1:0] <= irq_mask;
                end
                default: begin
                    o_prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_halt_taken;
        is_halt;
    endsequence
    sequence s_halt_effect;
        o_watchdog_timer_clear && o_prescaler_clear && o_osc_stop;
    endsequence

    a_rotr_result: assert property (
        is_rotr |=> o_result == {$past(i_carry), $past(i_file_rdata[7:1])} && o_carry == $past(i_file_rdata[0]))
        else $error("rotate right result wrong");
    a_rotl_result: assert property (
        is_rotl |=> o_result == {$past(i_file_rdata[6:0]), $past(i_carry)} && o_carry == $past(i_file_rdata[7]))
        else $error("rotate left result wrong");
    a_dest_route: assert property (
        is_rot |=> (o_file_we == $past(i_instr[7])) && (o_w_we == !$past(i_instr[7])))
        else $error("rotate destination wrong");
    a_decode_opcode: assert property (
        accept && (i_instr[13:9] != 5'h06) |=> !o_carry_we)
        else $error("non-rotate word decoded as rotate");
    a_file_address: assert property (
        is_rot |=> o_file_waddr == $past(i_instr[6:0]))
        else $error("file address not carried");
    a_only_carry: assert property (
        o_carry_we |-> !o_zero_we && !o_dc_we && $past(is_rot))
        else $error("rotate touched other flags");
    a_rot_single: assert property (
        is_rot ##1 !is_rot |=> !o_carry_we && !o_w_we && !o_file_we)
        else $error("rotate lasted over one cycle");
    a_halt_decode: assert property (
        accept && (i_instr != OPC_HALT) && (state == RSX_RUN) |=> !o_osc_stop)
        else $error("halt decoded from wrong word");
    a_halt_watchdog: assert property (
        s_halt_taken |=> s_halt_effect ##1 !o_watchdog_timer_clear)
        else $error("halt did not clear watchdog once");
    a_halt_status: assert property (
        s_halt_taken |=> o_watchdog_expiry_bit && !o_power_down_bit && $stable(o_carry))
        else $error("halt status bits wrong");
    a_halt_idle: assert property (
        o_osc_stop && !wake |=> o_osc_stop && !o_w_we && !o_file_we && !o_carry_we)
        else $error("core ran while halted");
    a_halt_one_cycle: assert property (
        s_halt_taken |=> o_osc_stop [*2] or (o_osc_stop ##1 !o_osc_stop))
        else $error("halt not entered in one cycle");
    a_carry_held: assert property (
        !is_rot |=> $stable(o_carry) && $stable(o_result))
        else $error("carry or result moved without rotate");
    a_pd_held: assert property (
        !is_halt |=> $stable(o_power_down_bit))
        else $error("power-down bit moved without halt");
    a_clear_only_halt: assert property (
        o_prescaler_clear |-> $past(is_halt))
        else $error("prescaler cleared without halt");
    a_halt_ignores: assert property (
        o_osc_stop |=> !o_watchdog_timer_clear && !o_carry_we)
        else $error("word executed while halted");
endmodule // rsx_exec
`default_nettype wire

// file: rsx_pkg.sv
// Purpose: shared constants for the rotate and halt execute block
// Assumes: 14-bit instruction words, 8-bit data, APB with 32-bit data
// Notes: all offsets are byte addresses
package rsx_pkg;
    // ------------------------------------------------------------
    // instruction encodings
    // ------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam logic [5:0] OPC_ROTR_HI = 6'h0C;
    localparam logic [5:0] OPC_ROTL_HI = 6'h0D;
    localparam logic [13:0] OPC_HALT = 14'h0063;
    localparam int DEST_BIT = 7;
    localparam int FADDR_W = 7;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_HALTED_BIT = 0;
    localparam int ST_EXPIRY_BIT = 1;
    localparam int ST_PWRDN_BIT = 2;
    localparam int ST_CARRY_BIT = 3;
    localparam int IRQ_ROT_BIT = 0;
    localparam int IRQ_HALT_BIT = 1;
    localparam int IRQ_WAKE_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic EXPIRY_RST = 1'b1;
    localparam logic PWRDN_RST = 1'b1;
    // ------------------------------------------------------------
    // control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RSX_RUN = 2'b01,
        RSX_HALTED = 2'b10
    } rsx_state_t;
endpackage

// file: tb_top.sv
// Purpose: self-checking bench for the rotate and halt execute block
// Assumes: results show one clock after the word, apb answers at once
// Notes: all stimulus launched by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rsx_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_clk = 1'h0;
    logic i_resetn = 1'h0;
    logic i_psel = 1'h0;
    logic i_penable = 1'h0;
    logic i_pwrite = 1'h0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic i_instr_valid = 1'h0;
    logic [13:0] i_instr = 14'h0;
    logic [7:0] i_file_rdata = 8'h00;
    logic i_carry = 1'h0;
    logic i_watchdog_expired = 1'h0;
    logic i_wake_pin = 1'h0;
    logic [31:0] o_prdata;
    logic [6:0] o_file_raddr, o_file_waddr;
    logic [7:0] o_result;
    logic o_pready, o_pslverr, o_file_we, o_w_we, o_carry_we, o_carry, o_zero_we, o_dc_we;
    logic o_watchdog_timer_clear, o_prescaler_clear, o_watchdog_expiry_bit, o_power_down_bit, o_osc_stop, o_irq;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic last_c = 1'h0;
    rsx_exec dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_file_raddr(o_file_raddr),
        .i_file_rdata(i_file_rdata), .i_carry(i_carry), .o_file_we(o_file_we), .o_file_waddr(o_file_waddr),
        .o_w_we(o_w_we), .o_result(o_result), .o_carry_we(o_carry_we), .o_carry(o_carry),
        .o_zero_we(o_zero_we), .o_dc_we(o_dc_we), .i_watchdog_expired(i_watchdog_expired),
        .i_wake_pin(i_wake_pin), .o_watchdog_timer_clear(o_watchdog_timer_clear),
        .o_prescaler_clear(o_prescaler_clear), .o_watchdog_expiry_bit(o_watchdog_expiry_bit),
        .o_power_down_bit(o_power_down_bit), .o_osc_stop(o_osc_stop), .o_irq(o_irq));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one apb transfer; wait on pready is bounded
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_err);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'h1 && n < 20);
        if (o_pready !== 1'h1) begin
            n_mismatch++;
            finish_test();
        end
        if (!wr) chk(o_prdata, exp);
        chk(o_pslverr, exp_err);
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask
    task automatic exec(input logic [13:0] w, input logic [7:0] fd, input logic c);
        @(posedge i_clk);
        i_instr <= w;
        i_file_rdata <= fd;
        i_carry <= c;
        i_instr_valid <= 1'h1;
        @(posedge i_clk);
        i_instr_valid <= 1'h0;
        #1;
    endtask
    task automatic rot(input logic [13:0] w, input logic [7:0] fd, input logic c);
        logic right;
        right = (w[13:8] == 6'h0C);
        exec(w, fd, c);
        chk(o_file_raddr, w[6:0]);
        chk(o_result, right ? {c, fd[7:1]} : {fd[6:0], c});
        chk(o_carry, right ? fd[0] : fd[7]);
        chk({o_file_we, o_w_we}, {w[7], ~w[7]});
        if (w[7]) chk(o_file_waddr, w[6:0]);
        chk({o_carry_we, o_zero_we, o_dc_we}, 3'h4);
        last_c = right ? fd[0] : fd[7];
        @(posedge i_clk);
        #1;
        chk({o_file_we, o_w_we, o_carry_we}, 3'h0);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_rotate;
        rot(14'h0C85, 8'hE6, 1'h0);
        rot(14'h0D00, 8'hE6, 1'h0);
        rot(14'h0CFF, 8'h01, 1'h1);
        rot(14'h0D7F, 8'h80, 1'h1);
        rot(14'h0DFF, 8'h7F, 1'h0);
        $display("rotate test done");
    endtask
    task automatic t_refuse;
        apb(1'h1, REG_CTRL, 32'h0, 32'h0, 1'h0);
        exec(14'h0C85, 8'hE6, 1'h0);
        chk({o_file_we, o_w_we, o_carry_we}, 3'h0);
        apb(1'h1, REG_CTRL, 32'h1, 32'h0, 1'h0);
        exec(14'h0E85, 8'hE6, 1'h0);
        chk({o_file_we, o_w_we, o_carry_we}, 3'h0);
        exec(14'h0062, 8'h00, 1'h0);
        chk({o_osc_stop, o_watchdog_timer_clear}, 2'h0);
        apb(1'h0, 8'h10, 32'h0, 32'h0, 1'h1);
        $display("refusal test done");
    endtask
    task automatic t_irq;
        apb(1'h0, REG_IRQ_STAT, 32'h0, 32'h1, 1'h0);
        apb(1'h1, REG_IRQ_MASK, 32'h1, 32'h0, 1'h0);
        #1;
        chk(o_irq, 1'h1);
        apb(1'h1, REG_IRQ_STAT, 32'h1, 32'h0, 1'h0);
        #1;
        chk(o_irq, 1'h0);
        $display("interrupt test done");
    endtask
    task automatic t_halt;
        int n;
        @(posedge i_clk);
        i_watchdog_expired <= 1'h1;
        @(posedge i_clk);
        i_watchdog_expired <= 1'h0;
        #1;
        chk(o_watchdog_expiry_bit, 1'h0);
        exec(OPC_HALT, 8'h00, 1'h0);
        chk({o_watchdog_timer_clear, o_prescaler_clear}, 2'h3);
        chk({o_watchdog_expiry_bit, o_power_down_bit}, 2'h2);
        chk({o_osc_stop, o_w_we, o_file_we, o_carry_we}, 4'h8);
        exec(14'h0C85, 8'hE6, 1'h0);
        chk({o_watchdog_timer_clear, o_prescaler_clear, o_w_we, o_file_we}, 4'h0);
        chk(o_osc_stop, 1'h1);
        apb(1'h0, REG_STATUS, 32'h0, {28'h0, last_c, 3'h3}, 1'h0);
        i_wake_pin <= 1'h1;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_osc_stop !== 1'h0 && n < 10);
        chk(o_osc_stop, 1'h0);
        @(posedge i_clk);
        i_wake_pin <= 1'h0;
        apb(1'h0, REG_IRQ_STAT, 32'h0, 32'h6, 1'h0);
        rot(14'h0C85, 8'hE6, 1'h1);
        $display("halt test done");
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'h1;
        #1;
        chk({o_watchdog_expiry_bit, o_power_down_bit, o_osc_stop, o_irq}, 4'hC);
        apb(1'h0, REG_CTRL, 32'h0, 32'h1, 1'h0);
        apb(1'h0, REG_IRQ_MASK, 32'h0, 32'h0, 1'h0);
        t_rotate();
        t_refuse();
        t_irq();
        t_halt();
        finish_test();
    end
    initial begin
        #5000000;
        n_mismatch++;
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
